// File: hdl/flash_sections_params.svh
// constants for the flash self-program section controller
`ifndef FLASH_SECTIONS_PARAMS_SVH
`define FLASH_SECTIONS_PARAMS_SVH
`define PAGE_ADDR_W       8
`define RW_LIMIT_PAGE     8'hE0
`define BOOT_START_0      8'hFC
`define BOOT_START_1      8'hF8
`define BOOT_START_2      8'hF0
`define BOOT_START_3      8'hE0
`define ERASE_TIME_NS     4000000
`define WRITE_TIME_NS     4000000
`define CLK_PERIOD_NS     40
`define ERASE_CYCLES      (`ERASE_TIME_NS / `CLK_PERIOD_NS)
`define WRITE_CYCLES      (`WRITE_TIME_NS / `CLK_PERIOD_NS)
`define OFF_CTRL          2'h0
`define OFF_IRQ_STAT      2'h1
`define OFF_IRQ_MASK      2'h2
`define CTRL_REREAD_BIT   0
`define STAT_BUSY_BIT     1
`define IRQ_DONE_BIT      0
`define IRQ_REJECT_BIT    1
`define IRQ_LOCKED_BIT    2
`define FUSE_RESET        2'h3
`endif

// File: hdl/flash_sections_pkg.sv
// types for the flash self-program section controller
package flash_sections_pkg;
  typedef enum logic [2:0]
  {
    S_IDLE = 3'b001,
    S_PROG = 3'b010,
    S_DONE = 3'b100
  } prog_state_e;
  typedef enum logic [1:0]
  {
    OP_LOAD  = 2'h0,
    OP_ERASE = 2'h1,
    OP_WRITE = 2'h2,
    OP_NONE  = 2'h3
  } prog_op_e;
  typedef struct packed
  {
    logic          valid;
    prog_op_e      op;
    logic [7:0]    targetPage;
    logic [7:0]    pcPage;
  } prog_req_s;
endpackage : flash_sections_pkg

// File: hdl/flash_self_program_sections.sv
// flash self-program access control, cpu stall and region busy tracking
// What this block does
// - no programming from application section
// - boot section may target any page
// - boot size fuses split sections, own locks
// - fixed read-while-write boundary splits flash
// - rw-region programming keeps cpu running
// - no-rw-region programming halts cpu throughout
// - rw-region reads blocked during programming
// - boot section always inside no-rw region
// - busy flag reads one while blocked
// - pages matter only during programming
// - rw-region erase or write sets busy
// - reread enable or page load clears busy
// - fuse and lock ones mean unprogrammed
`timescale 1ns/1ns
`include "flash_sections_params.svh"
module flash_self_program_sections
  import flash_sections_pkg::*;
#(
  parameter int ERASE_CNT = `ERASE_CYCLES,
  parameter int WRITE_CNT = `WRITE_CYCLES
)
(
  input  wire logic       mclk,
  input  wire logic       rst,
  input  wire prog_req_s  progReq,
  input  wire logic [1:0] bootSizeFuses,
  input  wire logic [1:0] appLockBits,
  input  wire logic [1:0] bootLockBits,
  input  wire logic [7:0] fetchPage,
  input  wire logic [1:0] regAddr,
  input  wire logic [7:0] regWdata,
  input  wire logic       regWr,
  input  wire logic       regRd,
  output logic      [7:0] regRdata,
  output logic            cpuHalt,
  output logic            fetchBlock,
  output logic            regionBusyFlag,
  output logic            flashProgStrobe,
  output logic            irq
);

  // ****************************************************************
  // section decode
  // ****************************************************************

  // boot start per fuse code; ones mean unprogrammed, so 2'h3 is smallest
  function automatic logic [7:0] boot_start(input logic [1:0] fz);
    unique case (fz)
      2'h3:    boot_start = `BOOT_START_0;
      2'h2:    boot_start = `BOOT_START_1;
      2'h1:    boot_start = `BOOT_START_2;
      default: boot_start = `BOOT_START_3;
    endcase
  endfunction : boot_start

  // fixed boundary, independent of fuses; every boot start sits at or above it
  function automatic logic in_rw_region(input logic [7:0] pg);
    in_rw_region = pg < `RW_LIMIT_PAGE;
  endfunction : in_rw_region

  logic [1:0]  fuseReg;
  logic [1:0]  fuseNext;
  logic        fromBoot;
  logic        tgtBoot;
  logic        lockOk;
  logic        accept;
  logic        isProg;

  // fuses captured by a clocked process, not by the reset itself
  always_comb
  begin
    fuseNext = rst ? `FUSE_RESET : bootSizeFuses;
  end

  always_ff @(posedge mclk)
  begin
    fuseReg <= fuseNext;
  end

  // locks per section: lock bit 0 low forbids writes to that section
  always_comb
  begin
    fromBoot = progReq.pcPage >= boot_start(fuseReg);
    tgtBoot  = progReq.targetPage >= boot_start(fuseReg);
    lockOk   = tgtBoot ? bootLockBits[0] : appLockBits[0];
    isProg   = (progReq.op == OP_ERASE) || (progReq.op == OP_WRITE);
    accept   = progReq.valid && fromBoot && (progReq.op != OP_NONE);
  end

  // ****************************************************************
  // programming sequencer
  // ****************************************************************

  prog_state_e stateReg;
  prog_state_e stateNext;
  logic [23:0] cntReg;
  logic [23:0] cntNext;
  logic        haltReg;
  logic        haltNext;
  logic        busyReg;
  logic        busyNext;
  logic        strobeReg;
  logic        strobeNext;
  logic        doneEv;
  logic        rejEv;
  logic        lockEv;
  logic        rereadWr;

  assign rereadWr = regWr && (regAddr == `OFF_CTRL) && regWdata[`CTRL_REREAD_BIT];

  // one operation at a time; a request outside S_IDLE is ignored
  always_comb
  begin
    stateNext  = stateReg;
    cntNext    = cntReg;
    haltNext   = haltReg;
    busyNext   = busyReg;
    strobeNext = 1'b0;
    doneEv     = 1'b0;
    rejEv      = 1'b0;
    lockEv     = 1'b0;
    unique case (stateReg)
      S_IDLE:
      begin
        if (progReq.valid && !accept)
        begin
          rejEv = 1'b1;
        end
        else if (accept && progReq.op == OP_LOAD)
        begin
          busyNext = 1'b0;
        end
        else if (accept && isProg && !lockOk)
        begin
          lockEv = 1'b1;
        end
        else if (accept && isProg)
        begin
          strobeNext = 1'b1;
          stateNext  = S_PROG;
          cntNext    = (progReq.op == OP_ERASE) ? 24'(ERASE_CNT - 1) : 24'(WRITE_CNT - 1);
          if (in_rw_region(progReq.targetPage))
          begin
            busyNext = 1'b1;
          end
          else
          begin
            haltNext = 1'b1;
          end
        end
        else if (rereadWr)
        begin
          busyNext = 1'b0;
        end
      end
      S_PROG:
      begin
        if (cntReg == 24'h000000)
        begin
          stateNext = S_DONE;
          haltNext  = 1'b0;
        end
        else
        begin
          cntNext = cntReg - 24'h000001;
        end
      end
      S_DONE:
      begin
        doneEv    = 1'b1;
        stateNext = S_IDLE;
      end
    endcase
    if (rst)
    begin
      stateNext  = S_IDLE;
      cntNext    = 24'h000000;
      haltNext   = 1'b0;
      busyNext   = 1'b0;
      strobeNext = 1'b0;
    end
  end

  always_ff @(posedge mclk)
  begin
    stateReg  <= stateNext;
    cntReg    <= cntNext;
    haltReg   <= haltNext;
    busyReg   <= busyNext;
    strobeReg <= strobeNext;
  end

  // ****************************************************************
  // registers and interrupt
  // ****************************************************************

  logic [2:0] statReg;
  logic [2:0] statNext;
  logic [2:0] maskReg;
  logic [2:0] maskNext;
  logic [7:0] rdReg;
  logic [7:0] rdNext;
  logic       irqReg;
  logic       irqNext;
  logic [2:0] evVec;

  assign evVec = {lockEv, rejEv, doneEv};

  // read of status clears it, but a same-cycle event still lands
  always_comb
  begin
    statNext = statReg;
    maskNext = maskReg;
    rdNext   = 8'h00;
    if (regRd)
    begin
      unique case (regAddr)
        `OFF_CTRL:     rdNext = {6'h00, busyReg, 1'b0};
        `OFF_IRQ_STAT: rdNext = {5'h00, statReg};
        `OFF_IRQ_MASK: rdNext = {5'h00, maskReg};
        default:       rdNext = 8'h00;
      endcase
      if (regAddr == `OFF_IRQ_STAT)
      begin
        statNext = 3'h0;
      end
    end
    if (regWr && regAddr == `OFF_IRQ_MASK)
    begin
      maskNext = regWdata[2:0];
    end
    statNext = statNext | evVec;
    irqNext  = |(statNext & maskNext);
    if (rst)
    begin
      statNext = 3'h0;
      maskNext = 3'h0;
      rdNext   = 8'h00;
      irqNext  = 1'b0;
    end
  end

  always_ff @(posedge mclk)
  begin
    statReg <= statNext;
    maskReg <= maskNext;
    rdReg   <= rdNext;
    irqReg  <= irqNext;
  end

  assign regRdata        = rdReg;
  assign cpuHalt         = haltReg;
  assign fetchBlock      = busyReg;
  assign regionBusyFlag  = busyReg;
  assign flashProgStrobe = strobeReg;
  assign irq             = irqReg;

  // ****************************************************************
  // checks
  // ****************************************************************

  a_app_no_prog: assert property (@(posedge mclk) disable iff (rst)
    (stateReg == S_IDLE && progReq.valid && !fromBoot) |=> !flashProgStrobe)
    else $error("programming started from application section");

  a_rw_sets_busy: assert property (@(posedge mclk) disable iff (rst)
    (stateReg == S_IDLE && accept && isProg && lockOk && in_rw_region(progReq.targetPage))
      |=> regionBusyFlag && !cpuHalt)
    else $error("read-while-write programming did not set busy");

  a_norw_halts: assert property (@(posedge mclk) disable iff (rst)
    (stateReg == S_PROG && $past(haltReg) && cntReg != 24'h000000) |=> cpuHalt)
    else $error("cpu released during no-read-while-write programming");

  // busy may linger from an older operation, so tie the check to the halt level
  a_rw_no_halt: assert property (@(posedge mclk) disable iff (rst)
    (stateReg == S_PROG && !cpuHalt) |=> !cpuHalt)
    else $error("cpu halted during read-while-write programming");

  a_reject_quiet: assert property (@(posedge mclk) disable iff (rst)
    (stateReg == S_IDLE && progReq.valid && !fromBoot) |=> $stable(regionBusyFlag))
    else $error("rejected request changed busy");

  a_load_clears: assert property (@(posedge mclk) disable iff (rst)
    (stateReg == S_IDLE && accept && progReq.op == OP_LOAD) |=> !regionBusyFlag)
    else $error("page load did not clear busy");

  a_busy_reads: assert property (@(posedge mclk) disable iff (rst)
    (regRd && regAddr == `OFF_CTRL) |=> regRdata[`STAT_BUSY_BIT] == $past(busyReg))
    else $error("busy flag read mismatch");

  a_busy_blocks: assert property (@(posedge mclk) disable iff (rst)
    (stateReg == S_PROG && !cpuHalt) |-> fetchBlock)
    else $error("region reads not blocked during programming");

  a_boot_in_norw: assert property (@(posedge mclk) disable iff (rst)
    !in_rw_region(boot_start(fuseReg)))
    else $error("boot section overlaps read-while-write region");

endmodule : flash_self_program_sections

// File: tb/cpu_fetch_model.sv
// cpu fetch and execute model that issues flash store requests
`timescale 1ns/1ns
module cpu_fetch_model
  import flash_sections_pkg::*;
(
  input  wire logic       mclk,
  input  wire logic       go,
  input  wire logic [1:0] opIn,
  input  wire logic [7:0] tgt,
  input  wire logic [7:0] pc,
  input  wire logic       fetchBlock,
  output prog_req_s       progReq,
  output logic      [7:0] fetchPage
);
  // idle request fields churn so a stale value is never trusted
  always @(posedge mclk)
  begin
    progReq   <= go ? {1'b1, opIn, tgt, pc} : {1'b0, 18'($urandom)};
    fetchPage <= fetchBlock ? (8'hF0 | 8'($urandom % 16)) : 8'($urandom);
  end
endmodule : cpu_fetch_model

// File: tb/testbench.sv
// self-checking bench for the flash self-program section controller
`timescale 1ns/1ns
module testbench
  import flash_sections_pkg::*;
;
  localparam int N = 8; // short programming time
  logic       mclk = 0, rst = 1, go = 0, regWr = 0, regRd = 0, rdPend = 0;
  logic [1:0] opIn = 0, fuses = 2'h3, appLock = 2'h3, bootLock = 2'h3, regAddr = 0;
  logic [7:0] tgt = 0, pc = 0, regWdata = 0, fetchPage, regRdata;
  logic       cpuHalt, fetchBlock, busy, strobe, irq;
  prog_req_s  progReq;
  int         fails = 0, nChecks = 0, nStrobe = 0, nHalt = 0, s0, h0;
  logic [7:0] expQ[$];
  logic [7:0] starts[4] = '{8'hE0, 8'hF0, 8'hF8, 8'hFC};

  always #20 mclk = ~mclk;

  flash_self_program_sections #(.ERASE_CNT(N), .WRITE_CNT(N)) i_dut (.mclk(mclk), .rst(rst),
    .progReq(progReq), .bootSizeFuses(fuses), .appLockBits(appLock), .bootLockBits(bootLock),
    .fetchPage(fetchPage), .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr),
    .regRd(regRd), .regRdata(regRdata), .cpuHalt(cpuHalt), .fetchBlock(fetchBlock),
    .regionBusyFlag(busy), .flashProgStrobe(strobe), .irq(irq));
  cpu_fetch_model i_cpu (.mclk(mclk), .go(go), .opIn(opIn), .tgt(tgt), .pc(pc),
    .fetchBlock(fetchBlock), .progReq(progReq), .fetchPage(fetchPage));

  task chk(input logic [15:0] seen, input logic [15:0] exp);
    nChecks++;
    if (seen !== exp)
    begin
      fails++;
      $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task tally_and_finish;
    $display("checks %0d mismatches %0d", nChecks, fails);
    if (fails == 0 && nChecks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : tally_and_finish

  // read data stand one cycle after the strobe, compared against the oldest note
  always @(posedge mclk)
  begin
    rdPend  <= regRd;
    nStrobe <= nStrobe + (strobe === 1'b1);
    nHalt   <= nHalt + (cpuHalt === 1'b1);
    if (rdPend)
      chk(regRdata, expQ.pop_front());
  end

  task wr(input logic [1:0] a, input logic [7:0] d);
    @(posedge mclk);
    regAddr  <= a;
    regWdata <= d;
    regWr    <= 1'b1;
    @(posedge mclk);
    regWr <= 1'b0;
  endtask : wr

  task rd(input logic [1:0] a, input logic [7:0] e);
    @(posedge mclk);
    regAddr <= a;
    regRd   <= 1'b1;
    expQ.push_back(e);
    @(posedge mclk);
    regRd <= 1'b0;
  endtask : rd

  task issue(input logic [1:0] op, input logic [7:0] t, input logic [7:0] p);
    @(posedge mclk);
    go   <= 1'b1;
    opIn <= op;
    tgt  <= t;
    pc   <= p;
    @(posedge mclk);
    go <= 1'b0;
    repeat (2) @(posedge mclk);
  endtask : issue

  // bounded wait so a stuck sequencer cannot hang the run
  task waitIrq;
    int i;
    i = 0;
    while (irq !== 1'b1 && i < 40)
    begin
      @(posedge mclk);
      i++;
    end
    if (irq !== 1'b1)
    begin
      fails++;
      tally_and_finish();
    end
  endtask : waitIrq

  initial
  begin
    void'($urandom(32'h635C8A74));
    repeat (2) @(posedge mclk);
    rst <= 1'b0;
    wr(2'h2, 8'h07);
    // rw-region erase from the boot section: cpu runs on, rw-region reads blocked
    s0 = nStrobe;
    issue(2'h1, 8'($urandom % 224), 8'hFC);
    chk(fetchBlock, 1'b1);
    chk(busy, 1'b1);
    chk(cpuHalt, 1'b0);
    rd(2'h0, 8'h02);
    waitIrq();
    chk(nStrobe - s0, 1);
    rd(2'h1, 8'h01);
    wr(2'h0, 8'h01);
    rd(2'h0, 8'h00);
    chk(busy, 1'b0);
    // no-rw-region write into the boot section itself halts the cpu throughout
    h0 = nHalt;
    issue(2'h2, 8'hFC, 8'hFC);
    chk(cpuHalt, 1'b1);
    waitIrq();
    chk(nHalt - h0, N);
    rd(2'h1, 8'h01);
    rd(2'h0, 8'h00);
    // last rw-region page, then a page load releases the busy flag
    issue(2'h1, 8'hDF, 8'hFC);
    chk(cpuHalt, 1'b0);
    waitIrq();
    rd(2'h1, 8'h01);
    rd(2'h0, 8'h02);
    issue(2'h0, 8'hDF, 8'hFC);
    rd(2'h0, 8'h00);
    // one page below each boot start is application code and is refused
    for (int f = 0; f < 4; f++)
    begin
      fuses <= f[1:0];
      s0 = nStrobe;
      issue(2'h2, 8'($urandom % 224), starts[f] - 8'h01);
      rd(2'h1, 8'h02);
      rd(2'h0, 8'h00);
      chk(nStrobe - s0, 0);
    end
    // a programmed lock bit refuses writes into its own section
    fuses   <= 2'h3;
    appLock <= 2'h2;
    issue(2'h2, 8'h10, 8'hFC);
    rd(2'h1, 8'h04);
    appLock  <= 2'h3;
    bootLock <= 2'h2;
    issue(2'h1, 8'hFD, 8'hFC);
    rd(2'h1, 8'h04);
    bootLock <= 2'h3;
    // masked events stay in status but keep the interrupt low
    wr(2'h2, 8'h00);
    issue(2'h1, 8'h20, 8'h20);
    repeat (2) @(posedge mclk);
    chk(irq, 1'b0);
    rd(2'h1, 8'h02);
    repeat (2) @(posedge mclk);
    tally_and_finish();
  end
endmodule : testbench
